// [include/awdg_pkg.sv]
// Package of constants for the self-clocked watchdog block
// Behaviour
// - Writing 1 to refresh clears the timeout counter; writing 0 does nothing.
// - Refresh bit is write-only and always reads back as 0.
// - Timeout with reset-enable set asserts reset output; with enable clear, none.
// - Reset-enable is readable and can be set once per reset, never cleared.
// - Rate bit 1 selects 10 ms period, 0 selects 20 ms; read/write.
// - Reset clears enable, rate and refresh; watchdog starts disabled, slow rate.
// - Watchdog counts and resets only in RUN mode.
// - Counting stops in STOP mode and resumes on return to RUN.
// - With reset-enable clear the counter is held at zero and idle.
package awdg_pkg;
  localparam logic [7:0] AWDG_CTRL_IDX = 8'h0A;
  localparam logic [11:0] AWDG_CTRL_ADDR = {AWDG_CTRL_IDX, 4'h0} >> 2;
  localparam int AWDG_REFRESH_BIT = 5;
  localparam int AWDG_ENABLE_BIT = 4;
  localparam int AWDG_RATE_BIT = 0;
  localparam logic [7:0] AWDG_CTRL_RESET = 8'h00;
  localparam int AWDG_CLK_HZ = 40000000;
  localparam int AWDG_FAST_MS = 10;
  localparam int AWDG_SLOW_MS = 20;
  localparam int AWDG_FAST_CYC = AWDG_CLK_HZ / 1000 * AWDG_FAST_MS;
  localparam int AWDG_SLOW_CYC = AWDG_CLK_HZ / 1000 * AWDG_SLOW_MS;
  localparam int AWDG_CNT_W = 24;
endpackage : awdg_pkg

// [core/awdg_top.sv]
// Self-clocked watchdog with APB control register
`timescale 1ns/10ps
module awdg_top #(
  parameter int FAST_CYC = awdg_pkg::AWDG_FAST_CYC,
  parameter int SLOW_CYC = awdg_pkg::AWDG_SLOW_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RUN_MODE,
  output logic WDOG_RESET
);
  localparam int CW = awdg_pkg::AWDG_CNT_W;
  logic run_meta_reg;
  logic run_reg;
  logic enable_reg;
  logic rate_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] end_val;
  logic wr_ctrl;
  logic rd_ctrl;
  logic refresh;
  logic expired;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: zero-wait slave, unmapped access gives error
  assign PREADY = 1'b1;
  assign wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == awdg_pkg::AWDG_CTRL_ADDR);
  assign rd_ctrl = PSEL && !PWRITE && (PADDR == awdg_pkg::AWDG_CTRL_ADDR);
  assign PSLVERR = PSEL && PENABLE && (PADDR != awdg_pkg::AWDG_CTRL_ADDR);
  assign refresh = wr_ctrl && PWDATA[awdg_pkg::AWDG_REFRESH_BIT];

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PWRITE && !PENABLE) begin
      // Refresh and spare bits read zero; unmapped reads zero
      PRDATA <= rd_ctrl ? {27'h0, enable_reg, 3'h0, rate_reg} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run mode pin synchroniser
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      run_meta_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      run_meta_reg <= RUN_MODE;
      run_reg <= run_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      enable_reg <= 1'b0;
    end else if (wr_ctrl && PWDATA[awdg_pkg::AWDG_ENABLE_BIT]) begin
      enable_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rate_reg <= 1'b0;
    end else if (wr_ctrl) begin
      rate_reg <= PWDATA[awdg_pkg::AWDG_RATE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout counter
  assign end_val = rate_reg ? CW'(FAST_CYC - 1) : CW'(SLOW_CYC - 1);
  assign expired = enable_reg && run_reg && (count_reg >= end_val);

  always_ff @(posedge CLK) begin
    if (SYS_RST || !enable_reg) begin
      count_reg <= '0;
    end else if (refresh || expired) begin
      count_reg <= '0;
    end else if (run_reg) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      WDOG_RESET <= 1'b0;
    end else begin
      WDOG_RESET <= expired;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence enable_write_s;
    wr_ctrl && PWDATA[awdg_pkg::AWDG_ENABLE_BIT];
  endsequence

  property enable_sticky_p;
    @(posedge CLK) disable iff (SYS_RST) enable_reg |=> enable_reg;
  endproperty
  enable_sticky_a: assert property (enable_sticky_p) else $error("enable cleared");

  enable_set_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    enable_write_s |=> enable_reg) else $error("enable not set");

  refresh_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    refresh && enable_reg |=> count_reg == '0) else $error("refresh missed");

  no_reset_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !$past(enable_reg) |-> !WDOG_RESET) else $error("reset while disabled");

  timeout_reset_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    enable_reg && run_reg && count_reg == end_val |=> WDOG_RESET)
    else $error("timeout lost");

  stop_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !run_reg && !refresh && enable_reg |=> $stable(count_reg)) else $error("counted in stop");

  off_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !enable_reg |=> count_reg == '0) else $error("counter ran while off");

  read_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    PRDATA[awdg_pkg::AWDG_REFRESH_BIT] == 1'b0 && PRDATA[3:2] == 2'h0)
    else $error("write-only bits read back");

  rate_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    wr_ctrl |=> rate_reg == $past(PWDATA[awdg_pkg::AWDG_RATE_BIT])) else $error("rate lost");

  stop_no_reset_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    !run_reg |=> !WDOG_RESET) else $error("reset in stop");
endmodule : awdg_top

// [verification/autonomous_watchdog_tb.sv]
// Self-checking testbench for the watchdog control register and timeout
`timescale 1ns/10ps
module autonomous_watchdog_tb;
  logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, RUN_MODE = 1;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, r;
  logic PREADY, PSLVERR, WDOG_RESET, e;
  int num_errors = 0, checked = 0, n;
  localparam logic [11:0] A = awdg_pkg::AWDG_CTRL_ADDR;
  always #12.5 CLK = ~CLK;
  awdg_top #(.FAST_CYC(40), .SLOW_CYC(80)) awdg_top_inst (.CLK(CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RUN_MODE(RUN_MODE),
    .WDOG_RESET(WDOG_RESET));
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 16) begin
      num_errors++;
      complete_run();
    end
  endtask : apb
  task quiet(input int c);
    repeat (c) begin
      @(posedge CLK);
      chk(WDOG_RESET, 0, "reset_out");
    end
  endtask : quiet
  task pulse(input int lo, input int hi);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (WDOG_RESET !== 1'b1 && n < hi + 8);
    chk(n >= lo && n <= hi, 1, "timeout_cycles");
    if (n >= hi + 8) complete_run();
  endtask : pulse
  task t_reset;
    SYS_RST <= 1'b1;
    repeat (6) @(posedge CLK);
    SYS_RST <= 1'b0;
    apb(0, A, 0);
    chk(r, 0, "ctrl_after_reset");
    chk(PREADY, 1, "pready");
    quiet(300);
  endtask : t_reset
  task t_fields;
    apb(1, A, 32'h31);
    apb(0, A, 0);
    chk(r, 32'h11, "ctrl_read");
    pulse(36, 46);
    apb(1, A, 0);
    apb(0, A, 0);
    chk(r, 32'h10, "enable_kept");
    apb(0, 12'h02C, 0);
    chk(e, 1, "unmapped_err");
    chk(r, 0, "unmapped_read");
  endtask : t_fields
  task t_refresh;
    apb(1, A, 32'h20);
    quiet(60);
    apb(1, A, 32'h20);
    pulse(76, 86);
  endtask : t_refresh
  task t_stop;
    apb(1, A, 32'h20);
    RUN_MODE <= 1'b0;
    quiet(300);
    RUN_MODE <= 1'b1;
    pulse(70, 88);
  endtask : t_stop
  initial begin
    t_reset();
    t_fields();
    t_refresh();
    t_stop();
    t_reset();
    complete_run();
  end
endmodule : autonomous_watchdog_tb
